// *** hw/fos_pkg.sv ***
// Package for the feed override select block: map, constants, carriers
package fos_pkg;
    // Register byte addresses
    localparam logic [7:0] FOS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] FOS_CUT_FILE_ADDR = 8'h04;
    localparam logic [7:0] FOS_SEC_FILE_ADDR = 8'h08;
    localparam logic [7:0] FOS_RAP_FILE_ADDR = 8'h0C;
    localparam logic [7:0] FOS_CMD_FEED_ADDR = 8'h10;
    localparam logic [7:0] FOS_RAP_BASE_ADDR = 8'h14;
    localparam logic [7:0] FOS_STATUS_ADDR = 8'h18;
    localparam logic [7:0] FOS_CUT_FEED_ADDR = 8'h1C;
    localparam logic [7:0] FOS_RAP_FEED_ADDR = 8'h20;
    // Control register field positions
    localparam int FOS_CTRL_ESTOP_BIT = 0;
    localparam int FOS_CTRL_CANCEL_BIT = 1;
    localparam int FOS_CTRL_SEC_BIT = 2;
    localparam int FOS_CTRL_CSEL_BIT = 3;
    localparam int FOS_CTRL_RSEL_BIT = 4;
    localparam int FOS_CTRL_RTR_BIT = 5;
    localparam int FOS_CTRL_AUTO_BIT = 6;
    localparam int FOS_CTRL_TAP_BIT = 7;
    localparam int FOS_CTRL_THR_BIT = 8;
    localparam int FOS_CTRL_CODE_LSB = 16;
    localparam int FOS_CTRL_RCODE_LSB = 24;
    // Reset values and percent scaling constants
    localparam logic [8:0] FOS_CUT_PCT_RST = 9'h000;
    localparam logic [15:0] FOS_SEC_RST = 16'h2710;
    localparam logic [15:0] FOS_PCT100_HUND = 16'h2710;
    localparam logic [8:0] FOS_PCT100 = 9'h064;
    localparam logic [8:0] FOS_CODE_STEP = 9'h00A;
    localparam logic [4:0] FOS_CODE_ALL_OFF = 5'h00;
    localparam logic [4:0] FOS_CODE_ZERO = 5'h1F;
    // Rapid code percentages
    localparam logic [8:0] FOS_RAP_P00 = 9'h064;
    localparam logic [8:0] FOS_RAP_P01 = 9'h032;
    localparam logic [8:0] FOS_RAP_P10 = 9'h019;
    localparam logic [8:0] FOS_RAP_P11 = 9'h001;
    // Timing: ladder scan and stop reaction delay
    localparam int FOS_CLK_HZ = 50_000_000;
    localparam int FOS_SCAN_US = 10_000;
    localparam int FOS_SCAN_CYC = FOS_SCAN_US * (FOS_CLK_HZ / 1_000_000);
    localparam int FOS_ESTOP_MS = 100;
    localparam int FOS_ESTOP_CYC = FOS_ESTOP_MS * (FOS_CLK_HZ / 1000);
    localparam logic [1:0] FOS_HTRANS_NONSEQ = 2'h2;
    // Ladder-scan sample of all override inputs
    typedef struct packed {
        logic estop;
        logic cancel;
        logic sec_en;
        logic cut_sel;
        logic rap_sel;
        logic rapid_req;
        logic auto_op;
        logic tapping;
        logic threading;
        logic [4:0] cut_code;
        logic [1:0] rap_code;
    } fos_inputs_s;
    // AHB-Lite request as seen by the slave
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } fos_ahb_req_s;
endpackage : fos_pkg

// *** hw/fos_feed_override.sv ***
// Feed override select: ladder-scan override decoding with AHB-Lite map
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Ladder emergency stop enters stop state and drops servo ready complete.
// - Stop reaction is one ladder scan plus 100 ms.
// - Automatic cutting feed equals commanded feed times selected override.
// - Override cancel, tapping or thread cutting force cutting override 100%.
// - All code bits off keeps previous override; reset value is 0%.
// - Second override multiplies again by file value in 0.01% steps.
// - Cutting method select picks code when low, file value when high.
// - Rapid speed equals parameter speed times selected rapid ratio.
// - Rapid override inputs ignored while rapid traverse request is low.
// - Rapid code 00 100%, 01 50%, 10 25%, 11 1%.
// - Rapid method select picks code when low, file value when high.
module fos_feed_override
    import fos_pkg::*;
#(
    parameter int SCAN_CYC = fos_pkg::FOS_SCAN_CYC,
    parameter int ESTOP_CYC = fos_pkg::FOS_ESTOP_CYC
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Motion results
    output logic o_servo_ready_complete,
    output logic o_emergency_stop,
    output logic [31:0] o_cut_feed,
    output logic [31:0] o_rapid_feed
);
    import fos_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [8:0] cut_file;
        logic [15:0] sec_file;
        logic [8:0] rap_file;
        logic [15:0] cmd_feed;
        logic [15:0] rap_base;
        fos_inputs_s smp;
        logic [8:0] code_pct;
        logic [31:0] scan_cnt;
        logic [31:0] stop_cnt;
        logic stop;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [31:0] cut_feed;
        logic [31:0] rap_feed;
    } fos_state_s;

    fos_state_s st;
    fos_state_s next_st;
    logic [8:0] cut_pct;
    logic [8:0] rap_pct;
    logic [47:0] cut_prod;
    logic [63:0] sec_prod;
    logic [31:0] sec_feed;
    logic scan_tick;
    logic bus_take;
    logic [7:0] a;
    logic [31:0] rd;
    logic [31:0] rap_prod;
    logic [31:0] cut_ref;

    assign scan_tick = (st.scan_cnt == 32'(SCAN_CYC - 1));
    assign bus_take = i_hsel && i_hready && i_htrans[1];
    assign a = i_haddr[7:0];

    // Override selection; cancel, tapping and threading win over cutting code and file value
    always_comb
    begin
        if (st.smp.cut_sel)
            cut_pct = st.cut_file;
        else
            cut_pct = st.code_pct;
        if (st.smp.cancel || st.smp.tapping || st.smp.threading)
            cut_pct = FOS_PCT100;
        unique case (st.smp.rap_code)
            2'b00: rap_pct = FOS_RAP_P00;
            2'b01: rap_pct = FOS_RAP_P01;
            2'b10: rap_pct = FOS_RAP_P10;
            2'b11: rap_pct = FOS_RAP_P11;
        endcase
        if (st.smp.rap_sel)
            rap_pct = st.rap_file;
        if (!st.smp.rapid_req)
            rap_pct = FOS_PCT100;
    end

    // Feed arithmetic; percent math keeps units of the commanded feed
    always_comb
    begin
        cut_prod = 48'(st.cmd_feed) * 48'(cut_pct);
        cut_ref = 32'(cut_prod / 48'(FOS_PCT100));
        sec_prod = 64'(cut_ref) * 64'(st.sec_file);
        if (st.smp.sec_en)
            sec_feed = 32'(sec_prod / 64'(FOS_PCT100_HUND));
        else
            sec_feed = cut_ref;
        // Full 32-bit product: a 9-bit rapid ratio (code or file) times a 16-bit base
        rap_prod = 32'(st.rap_base) * 32'(rap_pct);
    end

    // Read mux
    always_comb
    begin
        unique case (a)
            FOS_CTRL_ADDR: rd = st.ctrl;
            FOS_CUT_FILE_ADDR: rd = {23'h0, st.cut_file};
            FOS_SEC_FILE_ADDR: rd = {16'h0000, st.sec_file};
            FOS_RAP_FILE_ADDR: rd = {23'h0, st.rap_file};
            FOS_CMD_FEED_ADDR: rd = {16'h0000, st.cmd_feed};
            FOS_RAP_BASE_ADDR: rd = {16'h0000, st.rap_base};
            FOS_STATUS_ADDR: rd = {23'h0, cut_pct};
            FOS_CUT_FEED_ADDR: rd = st.cut_feed;
            FOS_RAP_FEED_ADDR: rd = st.rap_feed;
            default: rd = 32'h00000000;
        endcase
    end

    // Next-state logic
    always_comb
    begin
        next_st = st;
        // Scan timer drives the ladder sampling point
        next_st.scan_cnt = scan_tick ? 32'h00000000 : st.scan_cnt + 32'h1;
        if (scan_tick)
        begin
            next_st.smp.estop = st.ctrl[FOS_CTRL_ESTOP_BIT];
            next_st.smp.cancel = st.ctrl[FOS_CTRL_CANCEL_BIT];
            next_st.smp.sec_en = st.ctrl[FOS_CTRL_SEC_BIT];
            next_st.smp.cut_sel = st.ctrl[FOS_CTRL_CSEL_BIT];
            next_st.smp.rap_sel = st.ctrl[FOS_CTRL_RSEL_BIT];
            next_st.smp.rapid_req = st.ctrl[FOS_CTRL_RTR_BIT];
            next_st.smp.auto_op = st.ctrl[FOS_CTRL_AUTO_BIT];
            next_st.smp.tapping = st.ctrl[FOS_CTRL_TAP_BIT];
            next_st.smp.threading = st.ctrl[FOS_CTRL_THR_BIT];
            next_st.smp.cut_code = st.ctrl[FOS_CTRL_CODE_LSB +: 5];
            next_st.smp.rap_code = st.ctrl[FOS_CTRL_RCODE_LSB +: 2];
            // All bits off means the switch is between notches: hold
            if (st.ctrl[FOS_CTRL_CODE_LSB +: 5] != FOS_CODE_ALL_OFF)
                next_st.code_pct = 9'(FOS_CODE_ZERO
                    - st.ctrl[FOS_CTRL_CODE_LSB +: 5]) * FOS_CODE_STEP;
        end
        // Stop is software-processed, so it trails the sample by 100 ms
        if (!st.smp.estop)
        begin
            next_st.stop_cnt = 32'h00000000;
            next_st.stop = 1'b0;
        end
        else if (st.stop_cnt == 32'(ESTOP_CYC - 1))
            next_st.stop = 1'b1;
        else
            next_st.stop_cnt = st.stop_cnt + 32'h1;
        // Outputs registered; no motion while stopped, no cutting feed while not automatic
        next_st.cut_feed = (st.stop || !st.smp.auto_op) ? 32'h0 : sec_feed;
        next_st.rap_feed = st.stop ? 32'h0 : rap_prod / 32'(FOS_PCT100);
        // AHB data phase write
        if (st.wr_pend)
        begin
            unique case (st.wr_addr)
                FOS_CTRL_ADDR: next_st.ctrl = i_hwdata;
                FOS_CUT_FILE_ADDR: next_st.cut_file = i_hwdata[8:0];
                FOS_SEC_FILE_ADDR: next_st.sec_file = i_hwdata[15:0];
                FOS_RAP_FILE_ADDR: next_st.rap_file = i_hwdata[8:0];
                FOS_CMD_FEED_ADDR: next_st.cmd_feed = i_hwdata[15:0];
                FOS_RAP_BASE_ADDR: next_st.rap_base = i_hwdata[15:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        next_st.wr_pend = bus_take && i_hwrite;
        next_st.wr_addr = a;
        if (bus_take && !i_hwrite)
            next_st.rdata = rd;
    end

    // State register
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.sec_file <= FOS_SEC_RST;
            st.rap_file <= FOS_PCT100;
            st.cut_file <= FOS_PCT100;
            st.code_pct <= FOS_CUT_PCT_RST;
        end
        else
            st <= next_st;
    end

    // Bus answers are zero wait state and always OKAY
    assign o_hrdata = st.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_emergency_stop = st.stop;
    assign o_servo_ready_complete = !st.stop;
    assign o_cut_feed = st.cut_feed;
    assign o_rapid_feed = st.rap_feed;

    // Checks; the stop sample may clear at the very edge the stop rises,
    // so the stop delay is judged on the values one cycle back
    servo_drop_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_emergency_stop |-> !o_servo_ready_complete)
        else $error("servo ready with stop active");
    stop_clear_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !st.smp.estop |=> !o_emergency_stop)
        else $error("stop held after release");
    stop_feed_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_emergency_stop |=> o_cut_feed == 32'h0 && o_rapid_feed == 32'h0)
        else $error("motion while stopped");
    stop_wait_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $rose(st.stop) |-> $past(st.smp.estop)
            && $past(st.stop_cnt) == 32'(ESTOP_CYC - 1))
        else $error("stop came early");
    cut_full_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.auto_op && !st.stop && !st.smp.sec_en
            && cut_pct == FOS_PCT100
        |=> o_cut_feed == 32'($past(st.cmd_feed)))
        else $error("cut feed not commanded feed at 100");
    cut_none_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        cut_pct == 9'h000 |=> o_cut_feed == 32'h0)
        else $error("cut feed moved at 0 percent");
    cancel_hundred_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.cancel |-> cut_pct == FOS_PCT100)
        else $error("cancel did not force 100");
    tap_hundred_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.tapping |-> cut_pct == FOS_PCT100)
        else $error("tapping did not force 100");
    thread_hundred_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.threading |-> cut_pct == FOS_PCT100)
        else $error("threading did not force 100");
    code_zero_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        scan_tick && st.ctrl[FOS_CTRL_CODE_LSB +: 5] == 5'h1F
        |=> st.code_pct == 9'h000)
        else $error("code 11111 not 0");
    code_mid_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        scan_tick && st.ctrl[FOS_CTRL_CODE_LSB +: 5] == 5'h15
        |=> st.code_pct == 9'h064)
        else $error("code 10101 not 100");
    code_max_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        scan_tick && st.ctrl[FOS_CTRL_CODE_LSB +: 5] == 5'h01
        |=> st.code_pct == 9'h12C)
        else $error("code 00001 not 300");
    code_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        scan_tick && st.ctrl[FOS_CTRL_CODE_LSB +: 5] == 5'h00
        |=> $stable(st.code_pct))
        else $error("all-off code changed override");
    sec_scale_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.sec_en |-> 64'(sec_feed) * 64'(FOS_PCT100_HUND)
            <= 64'(cut_ref) * 64'(st.sec_file)
            && 64'(cut_ref) * 64'(st.sec_file)
            < 64'(sec_feed + 32'h1) * 64'(FOS_PCT100_HUND))
        else $error("second override ratio wrong");
    file_pick_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.cut_sel && !st.smp.cancel && !st.smp.tapping
            && !st.smp.threading |-> cut_pct == st.cut_file)
        else $error("file value not selected");
    code_pick_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !st.smp.cut_sel && !st.smp.cancel && !st.smp.tapping
            && !st.smp.threading |-> cut_pct == st.code_pct)
        else $error("code value not selected");
    rapid_full_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !st.stop && rap_pct == FOS_PCT100
        |=> o_rapid_feed == 32'($past(st.rap_base)))
        else $error("rapid feed not base speed at 100");
    rapid_ignore_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !st.smp.rapid_req |-> rap_pct == FOS_PCT100)
        else $error("rapid code used without request");
    rapid_half_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.rapid_req && !st.smp.rap_sel && st.smp.rap_code == 2'b01
        |-> rap_pct == 9'h032)
        else $error("rapid code 01 not 50");
    rapid_quarter_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.rapid_req && !st.smp.rap_sel && st.smp.rap_code == 2'b10
        |-> rap_pct == 9'h019)
        else $error("rapid code 10 not 25");
    rapid_file_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        st.smp.rapid_req && st.smp.rap_sel |-> rap_pct == st.rap_file)
        else $error("rapid file value not selected");
    scan_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !scan_tick |=> $stable(st.smp))
        else $error("inputs moved between scans");
endmodule : fos_feed_override

`default_nettype wire

// *** bench/fos_ladder_model.sv ***
// Ladder-side model: issues single-word AHB-Lite transfers
`timescale 1ns/1ps
`default_nettype none
module fos_ladder_model
(
    // Clock
    input wire logic i_clock,
    // Slave answer
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // Request towards the slave
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    // Idle bus before the first transfer
    initial
    begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    // One transfer; waits on hready, so a slow slave is handled too
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clock);
        o_hsel <= 1'b1;
        o_haddr <= {24'h000000, a};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        @(posedge i_clock);
        while (i_hready !== 1'b1) @(posedge i_clock);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        @(posedge i_clock);
        while (i_hready !== 1'b1) @(posedge i_clock);
        q = i_hrdata;
        // Released data lines show no stale value
        o_hwdata <= ~d;
    endtask
endmodule // fos_ladder_model
`default_nettype wire

// *** bench/fos_feed_override_tb.sv ***
// Self-checking bench for the feed override select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module fos_feed_override_tb;
    import fos_pkg::*;
    // Short scan and stop delays keep the run brief
    localparam int SCAN = 16;
    localparam int STOP = 40;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic hsel, hwrite, hready, hresp, servo, estop;
    logic [31:0] haddr, hwdata, hrdata, cut, rap, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] cmd, base, cfile, sec, rfile, pct;
    int fail_count = 0;
    int n_checks = 0;
    integer seed = 63934;
    // 50 MHz clock
    always #10 i_clock = ~i_clock;
    fos_feed_override #(.SCAN_CYC(SCAN), .ESTOP_CYC(STOP)) uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hready(hready), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_servo_ready_complete(servo), .o_emergency_stop(estop),
        .o_cut_feed(cut), .o_rapid_feed(rap));
    fos_ladder_model u_lad (.i_clock(i_clock), .i_hready(hready),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    // Expected effective cutting override in percent
    function automatic logic [31:0] exp_pct(input logic [31:0] c);
        logic [31:0] p;
        p = c[3] ? cfile : pct;
        if (c[1] | c[7] | c[8]) p = 32'h64;
        return p;
    endfunction
    // Expected cutting feed; wide maths avoids overflow in the bench
    function automatic logic [31:0] exp_cut(input logic [31:0] c);
        logic [63:0] p;
        logic [63:0] f;
        p = 64'(exp_pct(c));
        f = 64'(cmd) * p / 64'h64;
        if (c[2]) f = f * 64'(sec) / 64'h2710;
        if (!c[6]) f = 64'h0;
        return f[31:0];
    endfunction
    // Expected rapid feed
    function automatic logic [31:0] exp_rap(input logic [31:0] c);
        logic [63:0] p;
        case (c[25:24])
            2'h0: p = 64'h64;
            2'h1: p = 64'h32;
            2'h2: p = 64'h19;
            default: p = 64'h1;
        endcase
        if (c[4]) p = 64'(rfile);
        if (!c[5]) p = 64'h64;
        return 32'(64'(base) * p / 64'h64);
    endfunction
    // Load the value registers
    task automatic load();
        u_lad.xfer(1'b1, FOS_CMD_FEED_ADDR, cmd, rd);
        u_lad.xfer(1'b1, FOS_RAP_BASE_ADDR, base, rd);
        u_lad.xfer(1'b1, FOS_CUT_FILE_ADDR, cfile, rd);
        u_lad.xfer(1'b1, FOS_SEC_FILE_ADDR, sec, rd);
        u_lad.xfer(1'b1, FOS_RAP_FILE_ADDR, rfile, rd);
    endtask
    // Write the control word, let two scans pass, check both feeds
    task automatic apply(input logic [31:0] c);
        u_lad.xfer(1'b1, FOS_CTRL_ADDR, c, rd);
        if (c[20:16] != 5'h00) pct = (32'h1F - c[20:16]) * 32'h0A;
        repeat (2 * SCAN + 4) @(posedge i_clock);
        u_lad.xfer(1'b0, FOS_CUT_FEED_ADDR, 32'h0, rd);
        `CHK(rd, exp_cut(c))
        u_lad.xfer(1'b0, FOS_RAP_FEED_ADDR, 32'h0, rd);
        `CHK(rd, exp_rap(c))
        u_lad.xfer(1'b0, FOS_STATUS_ADDR, 32'h0, rd);
        `CHK(rd, exp_pct(c))
        `CHK(cut, exp_cut(c))
        `CHK(rap, exp_rap(c))
    endtask
    // Report counts and the verdict, then stop
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: the tests need well under 10000 cycles
    initial
    begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        pct = 32'h0;
        u_lad.xfer(1'b0, FOS_CUT_FILE_ADDR, 32'h0, rd);
        `CHK(rd, 32'h64)
        u_lad.xfer(1'b0, FOS_SEC_FILE_ADDR, 32'h0, rd);
        `CHK(rd, 32'h2710)
        u_lad.xfer(1'b0, 8'h40, 32'h0, rd);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        cmd = 32'h3E8;
        base = 32'h7D0;
        cfile = 32'h4B;
        sec = 32'h7FF8;
        rfile = 32'h0;
        load();
        // Decoded code value starts at 0 percent
        apply(32'h40);
        for (int k = 31; k >= 1; k--) apply(32'h40 | (k << 16));
        // All bits off keeps the last value
        apply(32'h40);
        apply(32'h1F0042);
        apply(32'h1F00C0);
        apply(32'h1F0140);
        apply(32'h48);
        apply(32'h4C);
        for (int k = 0; k < 4; k++) apply(32'h20 | (k << 24));
        apply(32'h03000000);
        apply(32'h03000030);
        // Random mix, each file value drawn at random within its range
        for (int i = 0; i < 24; i++)
        begin
            cmd = {20'h0, 12'($random(seed))};
            base = {16'h0, 16'($random(seed))};
            cfile = {23'h0, 9'($random(seed))} % 32'h12D;
            sec = {16'h0, 16'($random(seed))} % 32'h7FF9;
            rfile = {23'h0, 9'($random(seed))} % 32'h65;
            load();
            apply(32'($random(seed)) & 32'h031F01FE);
        end
        // Stop is slow: still running well inside one scan plus delay
        u_lad.xfer(1'b1, FOS_CTRL_ADDR, 32'h41, rd);
        repeat (30) @(posedge i_clock);
        #1;
        `CHK(estop, 1'b0)
        `CHK(servo, 1'b1)
        repeat (32) @(posedge i_clock);
        #1;
        `CHK(estop, 1'b1)
        `CHK(servo, 1'b0)
        u_lad.xfer(1'b0, FOS_CUT_FEED_ADDR, 32'h0, rd);
        `CHK(rd, 32'h0)
        apply(32'h40);
        `CHK(servo, 1'b1)
        print_verdict();
    end
endmodule // fos_feed_override_tb
`default_nettype wire
